// ==== rtl/trace_map.vh ====
// constants, register map and timing counts of the measurement trace buffer
// assumes a 250 MHz clock and an apb master on the register side
`ifndef TRACE_MAP_VH
`define TRACE_MAP_VH
`define CAP_LARGE 20'h0_F424_0
`define CAP_SMALL 20'h0_493E_0
`define A_CTRL 12'h000
`define A_SIZE 12'h004
`define A_READ 12'h008
`define A_CMD 12'h00C
`define A_TRIG 12'h010
`define A_WDATA 12'h014
`define A_FREE 12'h018
`define A_TOTAL 12'h01C
`define A_COUNT 12'h020
`define A_STAT 12'h024
`define A_DATA 12'h028
`define A_WPTR 12'h02C
`define MODE_HALT 2'h0
`define MODE_ONCE 2'h1
`define MODE_WRAP 2'h2
`define FMT_TEXT 2'h0
`define FMT_S32 2'h1
`define FMT_D64 2'h2
`define ST_IDLE 5'h01
`define ST_HDR 5'h02
`define ST_BODY 5'h04
`define ST_TERM 5'h08
`define ST_DONE 5'h10
`define LF_BYTE 8'h0a
`define HASH_BYTE 8'h23
`define COMMA_BYTE 8'h2c
`define ZERO_CHAR 8'h30
`define AUTO_TRIG_MS 32'h0000_000A
`define CLK_KHZ 32'h0003_D090
`define AUTO_TRIG_CYC (`AUTO_TRIG_MS * `CLK_KHZ)
`define TRIG_PULSE_CYC 8'h19
`define MEM_DEPTH 16
`define MEM_AW 4
`endif

// ==== rtl/trig_edge.v ====
// edge detector for one trigger input with polarity inversion
// assumes the input is synchronous to clk_in
`include "trace_map.vh"
module trig_edge (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // trigger line
    input wire level_in,
    input wire invert_in,
    // event
    output reg event_out
);
    reg last;
    wire now_lvl = level_in ^ invert_in;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            last <= 1'b0;
            event_out <= 1'b0;
        end else begin
            last <= now_lvl;
            event_out <= last & ~now_lvl;
        end
    end
endmodule // trig_edge

// ==== rtl/pulse_gen.v ====
// fixed-width pulse stretcher for the trigger-out line
// assumes a single-cycle start strobe
`include "trace_map.vh"
module pulse_gen (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // start strobe
    input wire start_in,
    // pulse
    output reg pulse_out
);
    reg [7:0] cnt;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt <= 8'h00;
            pulse_out <= 1'b0;
        end else if (start_in) begin
            cnt <= `TRIG_PULSE_CYC;
            pulse_out <= 1'b1;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            pulse_out <= (cnt != 8'h01);
        end else begin
            pulse_out <= 1'b0;
        end
    end
endmodule // pulse_gen

// ==== rtl/measurement_trace_buffer.v ====
// measurement trace buffer: record store, readout formatter, trigger select
// assumes an apb master; records pre-packed as 64-bit words by software
//
// Design decisions made here: the APB register port and the register addresses.
`include "trace_map.vh"
module measurement_trace_buffer (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // record capture
    input wire rec_valid_in,
    input wire [63:0] rec_meas_in,
    input wire [63:0] rec_calc_in,
    input wire [31:0] rec_time_in,
    // trigger inputs
    input wire key_press_in,
    input wire [7:0] io_pin_trigger_in,
    input wire [31:0] optical_trigger_line_in,
    input wire output_apply_in,
    input wire meas_start_in,
    // outputs
    output reg trigger_out,
    output reg trig_pulse_out,
    output reg [7:0] stream_byte_out,
    output reg stream_valid_out
);
    // configuration
    reg [1:0] mode;
    reg feed_calc;
    reg [1:0] fmt;
    reg swap;
    reg ts_prev;
    reg small_var;
    reg [19:0] size;
    reg [2:0] trig_src;
    reg [4:0] trig_sel;
    reg trig_inv;
    reg out_sense;
    // storage
    reg [63:0] mem [0:`MEM_DEPTH-1];
    reg [31:0] tmem [0:`MEM_DEPTH-1];
    reg [19:0] wptr;
    reg [19:0] count;
    reg [19:0] unread;
    reg [31:0] first_time;
    // readout
    reg [4:0] state;
    reg [19:0] rd_idx;
    reg [19:0] rd_left;
    reg [3:0] byte_idx;
    reg [1:0] hdr_idx;
    reg [31:0] prev_time;
    reg [31:0] timer;
    // reset loop index
    integer k;
    // capacity of the fitted variant
    wire [19:0] cap = small_var ? `CAP_SMALL : `CAP_LARGE;
    // access phase strobes
    wire wr = psel_in & penable_in & pwrite_in;
    wire rd = psel_in & penable_in & ~pwrite_in;
    wire [19:0] free_n = size - count;
    // bytes per value, binary formats
    wire [3:0] nbytes = (fmt == `FMT_D64) ? 4'h8 : 4'h4;
    // low index bits pick a fitted slot
    // larger sizes alias onto them
    wire [`MEM_AW-1:0] rd_slot = rd_idx[`MEM_AW-1:0];
    wire [63:0] rec_word = mem[rd_slot];
    wire [31:0] rec_t = tmem[rd_slot];
    // time as offset from the reference
    wire [31:0] rel_t = rec_t - (ts_prev ? prev_time : first_time);
    // upper record word above the offset
    wire [63:0] value = {rec_word[63:32], rel_t};
    // reversed_byte_order order walks down from the top
    wire [3:0] bsel = swap ? (nbytes - 4'h1 - byte_idx) : byte_idx;
    wire [7:0] vbyte = value[{bsel[2:0], 3'b000} +: 8];
    // text: sign, one hex nibble
    wire [7:0] hex = (value[3:0] < 4'ha) ?
        (`ZERO_CHAR + {4'h0, value[3:0]}) : (8'h37 + {4'h0, value[3:0]});
    // header: '#', one digit, byte count digit (records*nbytes low nibble)
    wire [7:0] body_cnt = rd_left[3:0] * nbytes;
    wire [7:0] hdr_byte = (hdr_idx == 2'h0) ? `HASH_BYTE :
        (hdr_idx == 2'h1) ? (`ZERO_CHAR + 8'h01) :
        (`ZERO_CHAR + {4'h0, body_cnt[3:0]});
    // start slot of a read, records left from it
    wire [1:0] rd_from = pwdata_in[31:30];
    wire [19:0] rd_start = (rd_from == 2'h1) ? unread :
        (rd_from == 2'h2) ? 20'h0_0000 : pwdata_in[19:0];
    wire [19:0] rd_tail = (rd_start < count) ? (count - rd_start)
                                             : 20'h0_0000;
    // trigger sources
    wire [7:0] pin_ev;
    // one edge detector per io pin
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            trig_edge u_edge (
                .clk_in(clk_in),
                .arst_n_in(arst_n_in),
                .level_in(io_pin_trigger_in[g]),
                .invert_in(trig_inv),
                .event_out(pin_ev[g])
            );
        end
    endgenerate
    // last levels for key and optical edges
    reg opt_last;
    reg key_last;
    reg bus_trig;
    wire opt_now = optical_trigger_line_in[trig_sel];
    reg next_trig;
    // one-cycle strobe of the chosen source
    always @* begin
        next_trig = 1'b0;
        case (trig_src)
            3'h0: next_trig = (timer == 32'h0000_0000);
            3'h1: next_trig = key_press_in & ~key_last;
            3'h2: next_trig = bus_trig;
            3'h3: next_trig = pin_ev[trig_sel[2:0]];
            3'h4: next_trig = opt_now & ~opt_last;
            default: next_trig = 1'b0;
        endcase
    end
    // start follows the trigger-out mode
    wire tp;
    pulse_gen u_pulse (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .start_in(out_sense ? meas_start_in : output_apply_in),
        .pulse_out(tp)
    );
    // capture only while not halted
    wire store = rec_valid_in & (mode != `MODE_HALT);
    // every configured slot in use
    wire full = (count == size);
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode <= `MODE_HALT;
            feed_calc <= 1'b0;
            fmt <= `FMT_TEXT;
            swap <= 1'b0;
            ts_prev <= 1'b0;
            small_var <= 1'b0;
            size <= `CAP_LARGE;
            trig_src <= 3'h0;
            trig_sel <= 5'h00;
            trig_inv <= 1'b0;
            out_sense <= 1'b0;
            wptr <= 20'h0_0000;
            count <= 20'h0_0000;
            unread <= 20'h0_0000;
            first_time <= 32'h0000_0000;
            state <= `ST_IDLE;
            rd_idx <= 20'h0_0000;
            rd_left <= 20'h0_0000;
            byte_idx <= 4'h0;
            hdr_idx <= 2'h0;
            prev_time <= 32'h0000_0000;
            timer <= `AUTO_TRIG_CYC - 32'h0000_0001;
            opt_last <= 1'b0;
            key_last <= 1'b0;
            bus_trig <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            trigger_out <= 1'b0;
            trig_pulse_out <= 1'b0;
            stream_byte_out <= 8'h00;
            stream_valid_out <= 1'b0;
            // storage cleared so early reads are defined
            for (k = 0; k < `MEM_DEPTH; k = k + 1) begin
                mem[k] <= 64'h0;
                tmem[k] <= 32'h0;
            end
        end else begin
            // strobes default low
            opt_last <= opt_now;
            key_last <= key_press_in;
            bus_trig <= 1'b0;
            trigger_out <= next_trig;
            trig_pulse_out <= tp;
            stream_valid_out <= 1'b0;
            // free-running period of the timed source
            timer <= (timer == 32'h0000_0000) ?
                (`AUTO_TRIG_CYC - 32'h0000_0001) : (timer - 32'h0000_0001);
            // answer one cycle after the access is taken
            pready_out <= psel_in & penable_in & ~pready_out;
            pslverr_out <= 1'b0;
            // record capture
            if (store && !(mode == `MODE_ONCE && full)) begin
                mem[wptr[`MEM_AW-1:0]] <= feed_calc ? rec_calc_in
                                                    : rec_meas_in;
                tmem[wptr[`MEM_AW-1:0]] <= rec_time_in;
                if (count == 20'h0_0000)
                    first_time <= rec_time_in;
                wptr <= (wptr + 20'h0_0001 == size) ? 20'h0_0000
                                                    : wptr + 20'h0_0001;
                // when full the oldest entry is lost
                if (!full)
                    count <= count + 20'h0_0001;
                else
                    unread <= (unread + 20'h0_0001 == size) ? 20'h0_0000
                              : unread + 20'h0_0001;
                // last free slot taken: stop by itself
                if (mode == `MODE_ONCE && count + 20'h0_0001 == size)
                    mode <= `MODE_HALT;
            end
            // readout sequencer
            case (state)
                `ST_IDLE: begin
                end
                `ST_HDR: begin
                    // '#', digit count, count digit
                    stream_valid_out <= 1'b1;
                    stream_byte_out <= hdr_byte;
                    hdr_idx <= hdr_idx + 2'h1;
                    if (hdr_idx == 2'h2)
                        state <= (rd_left == 20'h0_0000) ? `ST_TERM
                                                         : `ST_BODY;
                end
                `ST_BODY: begin
                    stream_valid_out <= 1'b1;
                    if (fmt == `FMT_TEXT) begin
                        stream_byte_out <= (byte_idx == 4'h0) ?
                            ((value[63]) ? 8'h2d : 8'h2b) :
                            (byte_idx == 4'h1) ? hex :
                            `COMMA_BYTE;
                    end else begin
                        stream_byte_out <= vbyte;
                    end
                    if (byte_idx == ((fmt == `FMT_TEXT) ? 4'h2
                                     : nbytes - 4'h1)) begin
                        // last byte of a record: next slot
                        byte_idx <= 4'h0;
                        // reference for the next offset
                        prev_time <= rec_t;
                        rd_idx <= (rd_idx + 20'h0_0001 == size) ?
                                  20'h0_0000 : rd_idx + 20'h0_0001;
                        unread <= rd_idx + 20'h0_0001;
                        rd_left <= rd_left - 20'h0_0001;
                        if (rd_left == 20'h0_0001)
                            state <= `ST_TERM;
                    end else begin
                        byte_idx <= byte_idx + 4'h1;
                    end
                end
                `ST_TERM: begin
                    stream_valid_out <= 1'b1;
                    stream_byte_out <= `LF_BYTE;
                    state <= `ST_DONE;
                end
                `ST_DONE: begin
                    // idle cycle before the next request
                    state <= `ST_IDLE;
                end
                default: state <= `ST_IDLE;
            endcase
            // register writes
            // taken in the first access cycle only
            if (wr && !pready_out) begin
                case (paddr_in)
                    // mode, feed, format, order, time, variant
                    `A_CTRL: begin
                        mode <= pwdata_in[1:0];
                        feed_calc <= pwdata_in[2];
                        fmt <= pwdata_in[5:4];
                        swap <= pwdata_in[6];
                        ts_prev <= pwdata_in[7];
                        small_var <= pwdata_in[8];
                    end
                    // size may change only while halted
                    `A_SIZE: begin
                        if (mode == `MODE_HALT &&
                            pwdata_in[31:20] == 12'h000 &&
                            pwdata_in[19:0] != 20'h0_0000 &&
                            pwdata_in[19:0] <= cap)
                            size <= pwdata_in[19:0];
                        else
                            pslverr_out <= 1'b1;
                    end
                    `A_READ: begin
                        // ignored while a stream runs
                        if (state == `ST_IDLE) begin
                            rd_idx <= rd_start;
                            rd_left <= pwdata_in[29] ? rd_tail
                                       : {11'h000, pwdata_in[28:20]};
                            prev_time <= first_time;
                            hdr_idx <= (fmt == `FMT_TEXT) ? 2'h3 : 2'h0;
                            byte_idx <= 4'h0;
                            state <= (fmt == `FMT_TEXT) ? `ST_BODY
                                                        : `ST_HDR;
                        end
                    end
                    // clear wins over a capture in one cycle
                    `A_CMD: begin
                        if (pwdata_in[0]) begin
                            count <= 20'h0_0000;
                            wptr <= 20'h0_0000;
                            unread <= 20'h0_0000;
                            mode <= `MODE_HALT;
                        end
                        if (pwdata_in[1])
                            bus_trig <= 1'b1;
                    end
                    // source, line, inversion, out mode
                    `A_TRIG: begin
                        trig_src <= pwdata_in[2:0];
                        trig_sel <= pwdata_in[8:4];
                        trig_inv <= pwdata_in[9];
                        out_sense <= pwdata_in[10];
                    end
                    default: pslverr_out <= 1'b1;
                endcase
            end
            // register reads
            // data stands with pready
            if (rd && !pready_out) begin
                case (paddr_in)
                    // control fields read back
                    `A_CTRL: prdata_out <= {23'h0, small_var, ts_prev,
                                            swap, fmt, 1'b0, feed_calc,
                                            mode};
                    `A_SIZE: prdata_out <= {12'h000, size};
                    `A_FREE: prdata_out <= {12'h000, free_n};
                    `A_TOTAL: prdata_out <= {12'h000, size};
                    `A_COUNT: prdata_out <= {12'h000, count};
                    `A_STAT: prdata_out <= {27'h0, state};
                    `A_WPTR: prdata_out <= {12'h000, unread};
                    `A_TRIG: prdata_out <= {21'h0, out_sense, trig_inv,
                                            trig_sel, 1'b0, trig_src};
                    // unmapped: refused, read as zero
                    default: begin
                        prdata_out <= 32'h0000_0000;
                        pslverr_out <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // measurement_trace_buffer

// ==== sim/apb_host.sv ====
// apb master model standing for the host controller
// assumes a slave that may add wait states before pready
module apb_host (
    // clock
    input wire logic clk_in,
    // apb master side
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [11:0] paddr_out,
    output logic [31:0] pwdata_out,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    bit timed_out = 1'b0;
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0000_0000;
    end
    // setup, then access held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 50);
        q = prdata_in;
        e = pslverr_in;
        timed_out = (n >= 50);
        psel_out <= 1'b0;
        penable_out <= 1'b0;
    endtask
endmodule // apb_host

// ==== sim/trace_buffer_assertions.sv ====
// checker of the trace buffer's apb answers and trigger outputs
// assumes binding to measurement_trace_buffer, one clock domain
module trace_buffer_checker (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // triggers
    input wire trigger_out,
    input wire trig_pulse_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire take = psel_in && penable_in && !pready_out;
    wire done = psel_in && penable_in && pready_out;
    wire bad_addr = paddr_in > 12'h02C;
    reg [7:0] hi_cnt;
    // cycles the trigger-out pulse has stood high
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            hi_cnt <= 8'h00;
        else if (trig_pulse_out)
            hi_cnt <= hi_cnt + 8'h01;
        else
            hi_cnt <= 8'h00;
    end
    a_answer_next: assert property (take |=> pready_out)
        else $error("no answer one cycle after access");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready_out |-> $past(take))
        else $error("pready without access");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (done && bad_addr |-> pslverr_out)
        else $error("unmapped access not refused");
    a_unmapped_zero: assert property (done && bad_addr && !pwrite_in
            |-> prdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_size_range: assert property (done && pwrite_in && paddr_in == 12'h004
            && (pwdata_in == 32'h0000_0000 || pwdata_in > 32'h000F_4240)
            |-> pslverr_out)
        else $error("size out of range accepted");
    a_trig_single: assert property (trigger_out |=> !trigger_out)
        else $error("trigger longer than one cycle");
    a_pulse_width: assert property ($fell(trig_pulse_out)
            |-> hi_cnt >= 8'h18 && hi_cnt <= 8'h1A)
        else $error("trigger-out pulse width wrong");
    a_pulse_cap: assert property (hi_cnt <= 8'h1A)
        else $error("trigger-out pulse too long");
    c_refused: cover property (done && pslverr_out);
    c_trigger: cover property (trigger_out);
    c_pulse: cover property ($rose(trig_pulse_out));
endmodule // trace_buffer_checker

bind measurement_trace_buffer trace_buffer_checker i_chk (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .trigger_out(trigger_out), .trig_pulse_out(trig_pulse_out));

// ==== sim/tb.sv ====
// self-checking bench of the trace buffer: registers, stream, triggers
// assumes apb_host drives the register bus and the checker is bound
`include "trace_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rec_valid = 1'b0;
    logic [63:0] rec_meas = 64'h3FF0_0000_0000_0000;
    logic [31:0] rec_time = 32'h0000_0000;
    logic key_press = 1'b0, out_apply = 1'b0, meas_start = 1'b0;
    logic [7:0] io_pin = 8'hFF;
    logic [31:0] optic = 32'h0000_0000;
    logic trigger, trig_pulse, stream_valid;
    logic [7:0] stream_byte;
    logic [7:0] buf_a [0:63];
    logic [7:0] buf_b [0:63];
    int nb;
    int err_count = 0;
    int compares = 0;

    initial forever #2 clk_in = ~clk_in;

    apb_host i_host (.clk_in(clk_in), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr));

    measurement_trace_buffer i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .rec_valid_in(rec_valid), .rec_meas_in(rec_meas),
        .rec_calc_in(~rec_meas), .rec_time_in(rec_time),
        .key_press_in(key_press), .io_pin_trigger_in(io_pin),
        .optical_trigger_line_in(optic), .output_apply_in(out_apply),
        .meas_start_in(meas_start), .trigger_out(trigger),
        .trig_pulse_out(trig_pulse), .stream_byte_out(stream_byte),
        .stream_valid_out(stream_valid));

    task automatic test_done();
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        i_host.xfer(w, a, d, q, e);
        if (i_host.timed_out) begin
            err_count++;
            $display("CHECK FAILED %0t no bus answer", $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic e);
        logic [31:0] q;
        logic pe;
        bus(1'b1, a, d, q, pe);
        cmp({31'h0, pe}, {31'h0, e});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic pe;
        bus(1'b0, a, 32'h0000_0000, q, pe);
        cmp(q, x);
    endtask
    task automatic push(input int n);
        repeat (n) begin
            @(posedge clk_in);
            rec_valid <= 1'b1;
            rec_time <= rec_time + 32'h0000_0010;
            rec_meas <= rec_meas + 64'h0000_0001_0000_0000;
            @(posedge clk_in);
            rec_valid <= 1'b0;
        end
    endtask
    // issue a readout and collect every streamed byte
    task automatic grab(input logic [31:0] cmd, input int len);
        nb = 0;
        wr(`A_READ, cmd, 1'b0);
        repeat (150) begin
            @(posedge clk_in);
            if (stream_valid === 1'b1 && nb < 64) begin
                buf_a[nb] = stream_byte;
                nb++;
            end
        end
        cmp(nb, len);
        cmp(buf_a[len - 1], `LF_BYTE);
    endtask
    task automatic trig_seen(input int x);
        int n = 0;
        repeat (8) begin
            @(posedge clk_in);
            if (trigger === 1'b1)
                n++;
        end
        cmp(n, x);
    endtask
    task automatic pulse_seen(input logic src, input logic sns, input int x);
        int n = 0;
        @(posedge clk_in);
        out_apply <= src;
        meas_start <= sns;
        @(posedge clk_in);
        out_apply <= 1'b0;
        meas_start <= 1'b0;
        repeat (40) begin
            @(posedge clk_in);
            if (trig_pulse === 1'b1)
                n++;
        end
        cmp(n > 0, x);
    endtask

    task automatic t_regs();
        rd(`A_CTRL, 32'h0000_0000);
        rd(`A_SIZE, {12'h000, `CAP_LARGE});
        rd(`A_COUNT, 32'h0000_0000);
        rd(`A_FREE, {12'h000, `CAP_LARGE});
        rd(`A_TOTAL, {12'h000, `CAP_LARGE});
        wr(12'h030, 32'h0000_0001, 1'b1);
        wr(`A_SIZE, 32'h0000_0000, 1'b1);
        wr(`A_SIZE, 32'h000F_4241, 1'b1);
        wr(`A_CTRL, 32'h0000_0100, 1'b0);
        wr(`A_SIZE, 32'h0004_93E1, 1'b1);
        wr(`A_SIZE, 32'h0004_93E0, 1'b0);
        wr(`A_SIZE, 32'h0000_0004, 1'b0);
        wr(`A_CTRL, 32'h0000_0001, 1'b0);
        wr(`A_SIZE, 32'h0000_0003, 1'b1);
        rd(`A_SIZE, 32'h0000_0004);
    endtask
    task automatic t_fill();
        push(5);
        rd(`A_COUNT, 32'h0000_0004);
        rd(`A_CTRL, 32'h0000_0000);
        rd(`A_FREE, 32'h0000_0000);
        wr(`A_CTRL, 32'h0000_0002, 1'b0);
        push(6);
        rd(`A_COUNT, 32'h0000_0004);
        rd(`A_CTRL, 32'h0000_0002);
        wr(`A_CMD, 32'h0000_0001, 1'b0);
        rd(`A_COUNT, 32'h0000_0000);
        rd(`A_CTRL, 32'h0000_0000);
    endtask
    task automatic t_read();
        wr(`A_CTRL, 32'h0000_0001, 1'b0);
        push(3);
        grab(32'h8020_0000, 7);
        cmp(buf_a[2], `COMMA_BYTE);
        rd(`A_WPTR, 32'h0000_0002);
        grab(32'h6000_0000, 4);
        rd(`A_WPTR, 32'h0000_0003);
        grab(32'h0010_0001, 4);
        wr(`A_CTRL, 32'h0000_0010, 1'b0);
        grab(32'hA000_0000, 16);
        cmp(buf_a[0], `HASH_BYTE);
        buf_b = buf_a;
        wr(`A_CTRL, 32'h0000_0050, 1'b0);
        grab(32'hA000_0000, 16);
        for (int r = 0; r < 12; r += 4)
            for (int i = 0; i < 4; i++)
                cmp(buf_a[3 + r + i], buf_b[6 + r - i]);
        wr(`A_CTRL, 32'h0000_0020, 1'b0);
        grab(32'hA000_0000, 28);
        cmp(buf_a[0], `HASH_BYTE);
    endtask
    task automatic t_feed();
        wr(`A_CMD, 32'h0000_0001, 1'b0);
        wr(`A_CTRL, 32'h0000_00A5, 1'b0);
        push(3);
        grab(32'hA000_0000, 28);
        cmp(buf_a[19], 8'h10);
        cmp(buf_a[26], {24'h0, ~rec_meas[63:56]});
    endtask
    task automatic t_trig();
        wr(`A_TRIG, 32'h0000_0001, 1'b0);
        key_press <= 1'b1;
        trig_seen(1);
        key_press <= 1'b0;
        trig_seen(0);
        wr(`A_TRIG, 32'h0000_0002, 1'b0);
        wr(`A_CMD, 32'h0000_0002, 1'b0);
        trig_seen(1);
        wr(`A_TRIG, 32'h0000_0023, 1'b0);
        io_pin[2] <= 1'b0;
        trig_seen(1);
        wr(`A_TRIG, 32'h0000_0223, 1'b0);
        io_pin[2] <= 1'b1;
        trig_seen(1);
        io_pin[2] <= 1'b0;
        trig_seen(0);
        wr(`A_TRIG, 32'h0000_01F4, 1'b0);
        optic[30] <= 1'b1;
        trig_seen(0);
        optic[31] <= 1'b1;
        trig_seen(1);
        wr(`A_TRIG, 32'h0000_0001, 1'b0);
        pulse_seen(1'b0, 1'b1, 0);
        pulse_seen(1'b1, 1'b0, 1);
        wr(`A_TRIG, 32'h0000_0401, 1'b0);
        rd(`A_TRIG, 32'h0000_0401);
        pulse_seen(1'b1, 1'b0, 0);
        pulse_seen(1'b0, 1'b1, 1);
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t_regs();
        t_fill();
        t_read();
        t_feed();
        t_trig();
        test_done();
    end
endmodule // tb
